/* File: design/cmd_admit.v */
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "cmd_admit_regs.vh"
module cmd_admit #(
   parameter QDEPTH   = 128,
   parameter QW       = 7,
   parameter IDW      = 6,
   parameter RSV_SLOTS = 0
) (
   // Clock and reset.
   input  wire        mclk,
   input  wire        rst,
   // AXI4-Lite write address and data.
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response.
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read.
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Media engine status, same clock.
   input  wire        fmt_done,
   input  wire        fmt_ok,
   input  wire        late_err,
   input  wire        site_flag,
   input  wire        site_ldpc,
   input  wire [1:0]  site_qual_sel,
   input  wire [31:0] site_lba,
   input  wire        wr_recovered,
   input  wire        next_buffered,
   input  wire        task_done,
   input  wire        link_reset,
   // Media engine requests.
   output reg         read_ahead_ff,
   output reg         buffer_flush_ff,
   output reg         mark_pending_ff,
   output reg         realloc_ff,
   output reg         queue_suspend_ff
);
   // ****************************************************************
   // Register state.
   // ****************************************************************
   reg [31:0]     ctrl_ff;
   reg            degraded_ff;
   reg            resv_ff;
   reg [IDW-1:0]  resv_maker_ff;
   reg [IDW-1:0]  resv_holder_ff;
   reg [7:0]      status_ff;
   reg [3:0]      sense_key_ff;
   reg [15:0]     sense_asc_ff;
   reg [7:0]      err_code_ff;
   reg [31:0]     lba_ff;
   reg            deferred_ff;
   reg            prio_busy_ff;
   reg            head_insert_ff;
   reg [QW:0]     qcount_ff;
   reg [QW:0]     init_q_ff [0:(1<<IDW)-1];
   reg            fmt_pend_ff;

   wire aw_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = aw_go;
   assign s_axi_wready  = aw_go;
   assign s_axi_arready = ~s_axi_rvalid;
   wire ar_go = s_axi_arvalid & ~s_axi_rvalid;

   // Command and task management writes decode the data word.
   wire          cmd_wr  = aw_go & (s_axi_awaddr == `REG_CMD);
   wire [7:0]    op      = s_axi_wdata[7:0];
   wire [IDW-1:0] ini    = s_axi_wdata[8+IDW-1:8];
   wire [IDW-1:0] tgt    = s_axi_wdata[16+IDW-1:16];
   wire          is_tmf  = s_axi_wdata[31];
   wire [1:0]    tmf     = s_axi_wdata[25:24];

   // ****************************************************************
   // Command classification.
   // ****************************************************************
   function is_prio;
      input [7:0] o;
      begin
         is_prio = (o == `OP_INQUIRY) | (o == `OP_REQ_SENSE) | (o == `OP_REPORT_LUNS);
      end
   endfunction

   function is_rd;
      input [7:0] o;
      begin
         is_rd = (o == `OP_READ6) | (o == `OP_READ10) | (o == `OP_VERIFY) |
                 (o == `OP_WRVERIFY);
      end
   endfunction

   function is_wr;
      input [7:0] o;
      begin
         is_wr = (o == `OP_WRITE6) | (o == `OP_WRITE10) | (o == `OP_WRSAME) |
                 (o == `OP_WRVERIFY);
      end
   endfunction

   // ****************************************************************
   // Admission decision.
   // ****************************************************************
   reg [7:0]  nxt_status;
   reg [3:0]  nxt_key;
   reg [15:0] nxt_asc;
   reg        conflict;
   reg        enq;
   reg        other_multi;
   reg        run_fmt;
   reg        rel_eff;
   reg        rsv_eff;
   integer    k;

   wire deg_on = degraded_ff & ~ctrl_ff[`CTRL_DEGOFF_BIT];
   wire maker  = resv_maker_ff == ini;
   wire holder = resv_holder_ff == ini;

   always @* begin
      conflict    = 1'b0;
      nxt_status  = `ST_GOOD;
      nxt_key     = 4'h0;
      nxt_asc     = 16'h0000;
      enq         = 1'b0;
      run_fmt     = 1'b0;
      rel_eff     = 1'b0;
      rsv_eff     = 1'b0;
      other_multi = 1'b0;
      for (k = 0; k < (1<<IDW); k = k + 1) begin
         if ((k[IDW-1:0] != ini) && (init_q_ff[k] > 1)) begin
            other_multi = 1'b1;
         end
      end
      if (resv_ff && !is_prio(op)) begin
         if (maker && holder) begin
            conflict = 1'b0;
         end else if (!maker && !holder) begin
            conflict = (op != `OP_RELEASE);
         end else if (maker) begin
            conflict = (op != `OP_RESERVE) && (op != `OP_RELEASE);
         end else begin
            conflict = (op == `OP_RESERVE);
         end
      end
      if (conflict) begin
         nxt_status = `ST_RESV_CONF;
      end else if (deferred_ff && !is_prio(op)) begin
         nxt_status = `ST_CHECK;
         nxt_key    = `SK_MEDIUM;
      end else if (deg_on && (op == `OP_TUR)) begin
         nxt_status = `ST_CHECK;
         nxt_key    = `SK_NOT_READY;
         nxt_asc    = `ASC_FMT_CORRUPT;
      end else if (deg_on && (is_rd(op) || is_wr(op))) begin
         nxt_status = `ST_CHECK;
         nxt_key    = `SK_MEDIUM;
         nxt_asc    = `ASC_FMT_CORRUPT;
      end else if (is_prio(op)) begin
         nxt_status = `ST_GOOD;
      end else if ((qcount_ff >= QDEPTH - RSV_SLOTS) ||
                   (other_multi && (init_q_ff[ini] != 0))) begin
         nxt_status = `ST_TSF;
      end else begin
         enq     = 1'b1;
         run_fmt = (op == `OP_FORMAT);
         rsv_eff = (op == `OP_RESERVE);
         rel_eff = (op == `OP_RELEASE) && resv_ff && maker;
      end
   end

   // ****************************************************************
   // Queue bookkeeping and reservation state.
   // ****************************************************************
   integer j;
   always @(posedge mclk) begin
      if (rst) begin
         qcount_ff <= {(QW+1){1'b0}};
         for (j = 0; j < (1<<IDW); j = j + 1) begin
            init_q_ff[j] <= {(QW+1){1'b0}};
         end
         resv_ff        <= 1'b0;
         resv_maker_ff  <= {IDW{1'b0}};
         resv_holder_ff <= {IDW{1'b0}};
         prio_busy_ff   <= 1'b0;
         head_insert_ff <= 1'b0;
      end else begin
         if (cmd_wr && is_tmf) begin
            if (tmf == `TMF_ABORT) begin
               if (init_q_ff[ini] != 0) begin
                  init_q_ff[ini] <= init_q_ff[ini] - 1'b1;
                  qcount_ff      <= qcount_ff - 1'b1;
               end
            end else if (tmf == `TMF_ABORT_SET) begin
               init_q_ff[ini] <= {(QW+1){1'b0}};
               qcount_ff      <= qcount_ff - init_q_ff[ini];
            end else begin
               qcount_ff <= {(QW+1){1'b0}};
               for (j = 0; j < (1<<IDW); j = j + 1) begin
                  init_q_ff[j] <= {(QW+1){1'b0}};
               end
               resv_ff <= 1'b0;
            end
         end else if (cmd_wr) begin
            if (is_prio(op)) begin
               prio_busy_ff   <= 1'b1;
               head_insert_ff <= prio_busy_ff;
            end
            if (enq) begin
               init_q_ff[ini] <= init_q_ff[ini] + 1'b1;
               qcount_ff      <= qcount_ff + 1'b1;
            end
            if (rsv_eff) begin
               resv_ff        <= 1'b1;
               resv_maker_ff  <= ini;
               resv_holder_ff <= tgt;
            end
            if (rel_eff) begin
               resv_ff <= 1'b0;
            end
         end else if (task_done) begin
            prio_busy_ff   <= 1'b0;
            head_insert_ff <= 1'b0;
            if (qcount_ff != 0) begin
               qcount_ff <= qcount_ff - 1'b1;
            end
         end
      end
   end

   // ****************************************************************
   // Status, sense and media side effects.
   // ****************************************************************
   always @(posedge mclk) begin
      if (rst) begin
         ctrl_ff          <= `CTRL_RESET_VAL;
         degraded_ff      <= 1'b0;
         fmt_pend_ff      <= 1'b0;
         status_ff        <= `ST_GOOD;
         sense_key_ff     <= 4'h0;
         sense_asc_ff     <= 16'h0000;
         err_code_ff      <= `ERR_CURRENT;
         lba_ff           <= 32'h0000_0000;
         deferred_ff      <= 1'b0;
         read_ahead_ff    <= 1'b0;
         buffer_flush_ff  <= 1'b1;
         mark_pending_ff  <= 1'b0;
         realloc_ff       <= 1'b0;
         queue_suspend_ff <= 1'b0;
      end else begin
         read_ahead_ff   <= 1'b0;
         buffer_flush_ff <= link_reset |
                            (cmd_wr & is_tmf & (tmf == `TMF_TGT_RESET));
         mark_pending_ff <= 1'b0;
         realloc_ff      <= 1'b0;
         if (aw_go && (s_axi_awaddr == `REG_CTRL)) begin
            ctrl_ff <= s_axi_wdata;
         end
         if (aw_go && (s_axi_awaddr == `REG_STATUS) && s_axi_wdata[0]) begin
            degraded_ff <= 1'b1;
         end
         if (cmd_wr && !is_tmf) begin
            status_ff    <= nxt_status;
            sense_key_ff <= nxt_key;
            sense_asc_ff <= nxt_asc;
            if (deferred_ff && !is_prio(op)) begin
               deferred_ff      <= 1'b0;
               queue_suspend_ff <= 1'b0;
            end
            if (run_fmt) begin
               fmt_pend_ff <= 1'b1;
            end
            if (op == `OP_REQ_SENSE && deg_on) begin
               sense_key_ff <= `SK_NOT_READY;
               sense_asc_ff <= `ASC_FMT_CORRUPT;
            end
            if (enq && is_rd(op) && !ctrl_ff[`CTRL_RCOFF_BIT] && !next_buffered) begin
               read_ahead_ff <= 1'b1;
            end
            if (enq && is_wr(op) && ctrl_ff[`CTRL_WCACHE_BIT]) begin
               status_ff <= `ST_GOOD;
            end
         end
         if (fmt_pend_ff && fmt_done) begin
            fmt_pend_ff <= 1'b0;
            status_ff   <= fmt_ok ? `ST_GOOD : `ST_CHECK;
            if (fmt_ok) begin
               degraded_ff <= 1'b0;
            end
         end
         if (late_err) begin
            deferred_ff      <= 1'b1;
            err_code_ff      <= `ERR_DEFERRED;
            queue_suspend_ff <= 1'b1;
         end
         if (site_flag) begin
            mark_pending_ff <= 1'b1;
            realloc_ff      <= wr_recovered;
            sense_key_ff    <= `SK_RECOVERED;
            sense_asc_ff    <= {site_ldpc ? `ASC_RECOV_L : `ASC_RECOV_NOL, 6'h00,
                                site_qual_sel};
            lba_ff          <= site_lba;
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite responses.
   // ****************************************************************
   reg [31:0] rd_word;
   always @* begin
      if (s_axi_araddr == `REG_CTRL) begin
         rd_word = ctrl_ff;
      end else if (s_axi_araddr == `REG_STATUS) begin
         rd_word = {26'h0, head_insert_ff, prio_busy_ff, queue_suspend_ff,
                    deferred_ff, resv_ff, deg_on};
      end else if (s_axi_araddr == `REG_RESULT) begin
         rd_word = {err_code_ff, 16'h0000, status_ff};
      end else if (s_axi_araddr == `REG_SENSE) begin
         rd_word = {12'h000, sense_key_ff, sense_asc_ff};
      end else if (s_axi_araddr == `REG_LBA) begin
         rd_word = lba_ff;
      end else if (s_axi_araddr == `REG_EVENT) begin
         rd_word = {20'h0, 2'b00, resv_holder_ff, 4'h0};
      end else if (s_axi_araddr == `REG_QCOUNT) begin
         rd_word = {{(31-QW){1'b0}}, qcount_ff};
      end else begin
         rd_word = 32'h0000_0000;
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'b00;
         s_axi_rdata  <= 32'h0000_0000;
      end else begin
         if (aw_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr > `REG_QCOUNT) ? 2'b10 : 2'b00;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (ar_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= (s_axi_araddr > `REG_QCOUNT) ? 2'b10 : 2'b00;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

/* File: design/cmd_admit_regs.vh */
`ifndef CMD_ADMIT_REGS_VH
`define CMD_ADMIT_REGS_VH
// ****************************************************************
// Register offsets (byte addresses).
// ****************************************************************
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_CMD         8'h08
`define REG_RESULT      8'h0C
`define REG_SENSE       8'h10
`define REG_LBA         8'h14
`define REG_EVENT       8'h18
`define REG_QCOUNT      8'h1C
// ****************************************************************
// Control register fields.
// ****************************************************************
`define CTRL_DEGOFF_BIT 4
`define CTRL_WCACHE_BIT 0
`define CTRL_RCOFF_BIT  1
`define CTRL_RRELOC_BIT 2
`define CTRL_WRELOC_BIT 3
`define CTRL_QPOL_LSB   5
`define CTRL_RESET_VAL  32'h0000_0000
// ****************************************************************
// Opcodes.
// ****************************************************************
`define OP_TUR          8'h00
`define OP_REQ_SENSE    8'h03
`define OP_FORMAT       8'h04
`define OP_READ6        8'h08
`define OP_WRITE6       8'h0A
`define OP_INQUIRY      8'h12
`define OP_RESERVE      8'h16
`define OP_RELEASE      8'h17
`define OP_READ10       8'h28
`define OP_WRITE10      8'h2A
`define OP_WRVERIFY     8'h2E
`define OP_VERIFY       8'h2F
`define OP_WRSAME       8'h41
`define OP_REPORT_LUNS  8'hA0
// ****************************************************************
// Status codes, sense keys and codes.
// ****************************************************************
`define ST_GOOD         8'h00
`define ST_CHECK        8'h02
`define ST_BUSY         8'h08
`define ST_RESV_CONF    8'h18
`define ST_TSF          8'h28
`define SK_RECOVERED    4'h1
`define SK_NOT_READY    4'h2
`define SK_MEDIUM       4'h3
`define ASC_FMT_CORRUPT 16'h3100
`define ASC_RECOV_NOL   8'h17
`define ASC_RECOV_L     8'h18
`define ERR_DEFERRED    8'h71
`define ERR_CURRENT     8'h70
// ****************************************************************
// Task management functions.
// ****************************************************************
`define TMF_ABORT       2'h0
`define TMF_ABORT_SET   2'h1
`define TMF_CLEAR_SET   2'h2
`define TMF_TGT_RESET   2'h3
`endif

/* File: verif/cmd_admit_asserts.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port checks of the admission block.
// ****************************************************************
module cmd_admit_checker (
   // Clock and reset.
   input wire        mclk,
   input wire        rst,
   // Register bus.
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_bvalid,
   input wire [1:0]  s_axi_bresp,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire [1:0]  s_axi_rresp,
   // Media side.
   input wire        late_err,
   input wire        link_reset,
   input wire        read_ahead_ff,
   input wire        buffer_flush_ff,
   input wire        site_flag,
   input wire        wr_recovered,
   input wire        mark_pending_ff,
   input wire        realloc_ff,
   input wire        queue_suspend_ff
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_wtake;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence s_rtake;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_wresp;
      s_wtake |=> s_axi_bvalid;
   endproperty
   property p_rresp;
      s_rtake |=> s_axi_rvalid;
   endproperty
   property p_wslverr;
      s_wtake ##0 (s_axi_awaddr > 8'h1C) |=> s_axi_bresp == 2'h2;
   endproperty
   property p_rslverr;
      s_rtake ##0 (s_axi_araddr > 8'h1C) |=> s_axi_rresp == 2'h2;
   endproperty
   property p_wblock;
      s_axi_bvalid |-> !s_axi_awready;
   endproperty
   property p_rblock;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   // The first cycle after reset must flush, or stale read-ahead data survives.
   property p_flush_rst;
      $fell(rst) |-> ##[0:1] buffer_flush_ff;
   endproperty
   property p_flush_link;
      link_reset |-> ##[1:2] buffer_flush_ff;
   endproperty
   property p_suspend;
      late_err |-> ##[1:2] queue_suspend_ff;
   endproperty
   property p_site;
      site_flag |=> mark_pending_ff && (realloc_ff == $past(wr_recovered));
   endproperty
   property p_ra_pulse;
      read_ahead_ff |=> !read_ahead_ff;
   endproperty
   a_wresp:      assert property (p_wresp) else $error("write response missing");
   a_rresp:      assert property (p_rresp) else $error("read response missing");
   a_wslverr:    assert property (p_wslverr) else $error("unmapped write not refused");
   a_rslverr:    assert property (p_rslverr) else $error("unmapped read not refused");
   a_wblock:     assert property (p_wblock) else $error("second write taken");
   a_rblock:     assert property (p_rblock) else $error("second read taken");
   a_flush_rst:  assert property (p_flush_rst) else $error("no flush after reset");
   a_flush_link: assert property (p_flush_link) else $error("no flush on link reset");
   a_suspend:    assert property (p_suspend) else $error("queue not suspended");
   a_ra_pulse:   assert property (p_ra_pulse) else $error("read-ahead not a pulse");
   a_site:       assert property (p_site) else $error("site not marked");
endmodule

/* File: verif/media_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Media engine model; DLY sets how slowly it answers.
// ****************************************************************
module media_model #(
   parameter int DLY = 2
) (
   // Clock, reset and requests from the bench.
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [2:0]  req,
   input  wire logic        req_ok,
   // Status towards the block.
   output logic             fmt_done,
   output logic             fmt_ok,
   output logic             late_err,
   output logic             site_flag,
   output logic             site_ldpc,
   output logic [1:0]       site_qual_sel,
   output logic [31:0]      site_lba,
   output logic             wr_recovered,
   output logic             next_buffered,
   output logic             task_done
);
   logic [2:0] pend;
   logic       ok_ff;
   int         cnt;
   always @(posedge mclk) begin
      fmt_done <= 1'b0;
      late_err <= 1'b0;
      site_flag <= 1'b0;
      task_done <= 1'b0;
      // The LBA and LDPC qualifiers do not hold their value once the flag has gone.
      if (site_flag) begin
         site_lba <= ~site_lba;
         site_ldpc <= ~site_ldpc;
      end
      if (rst) begin
         pend <= 3'h0;
         cnt <= 0;
         ok_ff <= 1'b0;
         fmt_ok <= 1'b0;
         site_ldpc <= 1'b0;
         site_qual_sel <= 2'h0;
         site_lba <= 32'h0000_0000;
         wr_recovered <= 1'b0;
         next_buffered <= 1'b0;
      end else if (req == 3'h5) begin
         next_buffered <= req_ok;
      end else if (req != 3'h0) begin
         pend <= req;
         ok_ff <= req_ok;
         cnt <= DLY;
      end else if (pend != 3'h0) begin
         if (cnt != 0) begin
            cnt <= cnt - 1;
         end else begin
            pend <= 3'h0;
            fmt_done <= (pend == 3'h1);
            fmt_ok <= ok_ff;
            late_err <= (pend == 3'h2);
            site_flag <= (pend == 3'h3);
            site_ldpc <= ok_ff;
            site_qual_sel <= 2'h2;
            site_lba <= 32'h0000_1234;
            wr_recovered <= ok_ff;
            task_done <= (pend == 3'h4);
         end
      end
   end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`include "cmd_admit_regs.vh"
module testbench;
   logic        mclk, rst, link_reset, req_ok;
   logic [2:0]  req;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, rdat;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  bseen;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp, site_qual_sel;
   wire  [31:0] s_axi_rdata, site_lba;
   wire         fmt_done, fmt_ok, late_err, site_flag, site_ldpc, wr_recovered;
   wire         next_buffered, task_done, read_ahead_ff, buffer_flush_ff;
   wire         mark_pending_ff, realloc_ff, queue_suspend_ff;
   int          error_cnt, checks_done, ra_cnt, ra0;
   cmd_admit #(.QDEPTH(4), .QW(2)) dut (.*);
   media_model #(.DLY(2)) partner (.*);
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) if (read_ahead_ff === 1'b1) ra_cnt <= ra_cnt + 1;
   // ****************************************************************
   // Checking and closing.
   // ****************************************************************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // ****************************************************************
   // Bus master; every wait is bounded.
   // ****************************************************************
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin @(posedge mclk); n++; end while (s_axi_awready !== 1'b1 && n < 50);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do begin @(posedge mclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 100);
      bseen = s_axi_bresp;
      if (n >= 100) begin error_cnt++; report_and_stop(); end
   endtask
   task automatic axr(input logic [7:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin @(posedge mclk); n++; end while (s_axi_arready !== 1'b1 && n < 50);
      s_axi_arvalid <= 1'b0;
      do begin @(posedge mclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 100);
      rdat = s_axi_rdata;
      if (n >= 100) begin error_cnt++; report_and_stop(); end
   endtask
   task automatic issue(input logic [7:0] op, input logic [5:0] ini, input logic [5:0] tgt);
      axw(`REG_CMD, {10'h000, tgt, 2'h0, ini, op});
   endtask
   task automatic cmd(input logic [7:0] op, input logic [5:0] ini, input logic [5:0] tgt,
                      input logic [7:0] st);
      issue(op, ini, tgt);
      axr(`REG_RESULT);
      chk({24'h00_0000, rdat[7:0]}, {24'h00_0000, st});
   endtask
   task automatic tmf(input logic [1:0] fn, input logic [5:0] ini);
      axw(`REG_CMD, {1'b1, 5'h00, fn, 10'h000, ini, 8'h00});
   endtask
   task automatic sense(input logic [31:0] e);
      axr(`REG_SENSE);
      chk({12'h000, rdat[19:0]}, e);
   endtask
   task automatic stb(input int i, input logic v);
      axr(`REG_STATUS);
      chk({31'h0000_0000, rdat[i]}, {31'h0000_0000, v});
   endtask
   task automatic qcnt(input logic [31:0] e);
      axr(`REG_QCOUNT);
      chk(rdat, e);
   endtask
   task automatic mreq(input logic [2:0] c, input logic ok);
      req <= c;
      req_ok <= ok;
      @(posedge mclk);
      req <= 3'h0;
      repeat (6) @(posedge mclk);
   endtask
   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      {rst, link_reset, req_ok, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h21;
      {s_axi_arvalid, s_axi_rready, req, s_axi_awaddr, s_axi_araddr} = 21'h00_0000;
      {s_axi_wdata, rdat, s_axi_wstrb} = 68'h0_0000_0000_0000_000F;
      {error_cnt, checks_done, ra_cnt} = '0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      axr(`REG_CTRL);
      chk(rdat, `CTRL_RESET_VAL);
      axw(8'h20, 32'h0000_0001);
      chk({30'h0000_0000, bseen}, 32'h0000_0002);
      $display("test reset done");
      axw(`REG_STATUS, 32'h0000_0001);
      cmd(`OP_TUR, 6'h01, 6'h00, `ST_CHECK);
      sense(32'h0002_3100);
      cmd(`OP_READ10, 6'h01, 6'h00, `ST_CHECK);
      sense(32'h0003_3100);
      cmd(`OP_INQUIRY, 6'h01, 6'h00, `ST_GOOD);
      cmd(`OP_REQ_SENSE, 6'h01, 6'h00, `ST_GOOD);
      sense(32'h0002_3100);
      stb(5, 1'b1);
      mreq(3'h4, 1'b0);
      stb(4, 1'b0);
      issue(`OP_FORMAT, 6'h01, 6'h00);
      mreq(3'h1, 1'b0);
      stb(0, 1'b1);
      issue(`OP_FORMAT, 6'h01, 6'h00);
      mreq(3'h1, 1'b1);
      stb(0, 1'b0);
      axw(`REG_CTRL, 32'h0000_0010);
      axw(`REG_STATUS, 32'h0000_0001);
      cmd(`OP_TUR, 6'h01, 6'h00, `ST_GOOD);
      issue(`OP_FORMAT, 6'h01, 6'h00);
      mreq(3'h1, 1'b1);
      axw(`REG_CTRL, 32'h0000_0000);
      $display("test degraded done");
      tmf(`TMF_CLEAR_SET, 6'h01);
      cmd(`OP_RESERVE, 6'h01, 6'h02, `ST_GOOD);
      stb(1, 1'b1);
      cmd(`OP_TUR, 6'h03, 6'h00, `ST_RESV_CONF);
      cmd(`OP_INQUIRY, 6'h03, 6'h00, `ST_GOOD);
      cmd(`OP_REPORT_LUNS, 6'h03, 6'h00, `ST_GOOD);
      cmd(`OP_RELEASE, 6'h03, 6'h00, `ST_GOOD);
      stb(1, 1'b1);
      cmd(`OP_TUR, 6'h01, 6'h00, `ST_RESV_CONF);
      cmd(`OP_RESERVE, 6'h01, 6'h02, `ST_GOOD);
      tmf(`TMF_ABORT_SET, 6'h01);
      cmd(`OP_RESERVE, 6'h02, 6'h02, `ST_RESV_CONF);
      cmd(`OP_TUR, 6'h02, 6'h00, `ST_GOOD);
      cmd(`OP_RELEASE, 6'h02, 6'h00, `ST_GOOD);
      stb(1, 1'b1);
      cmd(`OP_RELEASE, 6'h01, 6'h00, `ST_GOOD);
      tmf(`TMF_CLEAR_SET, 6'h01);
      cmd(`OP_RESERVE, 6'h04, 6'h04, `ST_GOOD);
      cmd(`OP_TUR, 6'h04, 6'h00, `ST_GOOD);
      cmd(`OP_RELEASE, 6'h04, 6'h00, `ST_GOOD);
      stb(1, 1'b0);
      $display("test reserve done");
      tmf(`TMF_CLEAR_SET, 6'h01);
      repeat (3) issue(`OP_READ10, 6'h01, 6'h00);
      issue(`OP_READ10, 6'h02, 6'h00);
      qcnt(32'h0000_0004);
      cmd(`OP_READ10, 6'h01, 6'h00, `ST_TSF);
      cmd(`OP_INQUIRY, 6'h05, 6'h00, `ST_GOOD);
      qcnt(32'h0000_0004);
      tmf(`TMF_ABORT_SET, 6'h02);
      qcnt(32'h0000_0003);
      tmf(`TMF_CLEAR_SET, 6'h03);
      qcnt(32'h0000_0000);
      $display("test queue done");
      axw(`REG_CTRL, 32'h0000_0001);
      cmd(`OP_WRITE10, 6'h01, 6'h00, `ST_GOOD);
      mreq(3'h2, 1'b0);
      stb(3, 1'b1);
      cmd(`OP_TUR, 6'h01, 6'h00, `ST_CHECK);
      chk({24'h00_0000, rdat[31:24]}, 32'h0000_0071);
      mreq(3'h3, 1'b1);
      axr(`REG_LBA);
      chk(rdat, 32'h0000_1234);
      axr(`REG_SENSE);
      chk({20'h0_0000, rdat[19:8]}, 32'h0000_0118);
      $display("test deferred done");
      ra0 = ra_cnt;
      issue(`OP_READ10, 6'h01, 6'h00);
      @(posedge mclk);
      chk(ra_cnt - ra0, 32'h0000_0001);
      axw(`REG_CTRL, 32'h0000_0002);
      issue(`OP_READ10, 6'h01, 6'h00);
      @(posedge mclk);
      chk(ra_cnt - ra0, 32'h0000_0001);
      axw(`REG_CTRL, 32'h0000_0000);
      mreq(3'h5, 1'b1);
      issue(`OP_READ10, 6'h01, 6'h00);
      @(posedge mclk);
      chk(ra_cnt - ra0, 32'h0000_0001);
      link_reset <= 1'b1;
      @(posedge mclk);
      link_reset <= 1'b0;
      repeat (4) @(posedge mclk);
      $display("test read ahead done");
      report_and_stop();
   end
endmodule
bind cmd_admit cmd_admit_checker chk_i (.*);
